//--- rtl/srf_port.sv
// Purpose: Serial slave port to the register file of a tilt sensor
// Assumes: Master keeps frame spacing and clock limits
// Notes: Write port to a byte store; ready flag after recovery
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Direction bit then seven address bits
// - Write frame stores following byte
// - Read frame data bits ignored
// - Setting 0x07 or below means fast mode
// - Power-on data delay 150 or 190 ms
// - Reset 30/70 ms, sleep 2.5 ms recovery
// - Default averaging settles in about 1.28 s
// - Mode 3, sample on rising edge
// - Sixteen bits, most significant first
module srf_port #(
   parameter int POWER_ON_FAST = srf_pkg::POWER_ON_FAST_CYC,
   parameter int POWER_ON_NORM = srf_pkg::POWER_ON_NORM_CYC,
   parameter int RESET_REC_FAST = srf_pkg::RESET_REC_FAST_CYC,
   parameter int RESET_REC_NORM = srf_pkg::RESET_REC_NORM_CYC,
   parameter int SLEEP_REC = srf_pkg::SLEEP_REC_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic power_on,
   input wire logic sleep_exit,
   input wire logic [7:0] sample_period_setting,
   output logic wr_strobe,
   output logic [6:0] wr_addr,
   output logic [7:0] wr_data,
   output logic fast_mode,
   output logic data_ready
);
   // ----------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic srst_n;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign srst_n = rst_sync[1];

   logic [1:0] s_sclk, s_cs, s_din, s_sleep;
   logic sclk_d, sleep_d;
   logic [1:0] next_s_sclk, next_s_cs, next_s_din, next_s_sleep;
   logic next_sclk_d, next_sleep_d;
   always_comb begin
      next_s_sclk = {s_sclk[0], sclk};
      next_s_cs = {s_cs[0], cs_n};
      next_s_din = {s_din[0], din};
      next_s_sleep = {s_sleep[0], sleep_exit};
      next_sclk_d = s_sclk[1];
      next_sleep_d = s_sleep[1];
   end
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         s_sclk <= 2'b11;
         s_cs <= 2'b11;
         s_din <= 2'b00;
         s_sleep <= 2'b00;
         sclk_d <= 1'b1;
         sleep_d <= 1'b0;
      end else begin
         s_sclk <= next_s_sclk;
         s_cs <= next_s_cs;
         s_din <= next_s_din;
         s_sleep <= next_s_sleep;
         sclk_d <= next_sclk_d;
         sleep_d <= next_sleep_d;
      end
   end
   logic sclk_rise, sleep_rise;
   assign sclk_rise = s_sclk[1] && !sclk_d;
   assign sleep_rise = s_sleep[1] && !sleep_d;

   // ----------------------------------------
   // Frame shifter
   // ----------------------------------------
   srf_frame_if fr ();
   srf_shifter u_srf_shifter (
      .mclk(mclk),
      .rst_n(srst_n),
      .sclk_rise(sclk_rise),
      .cs_n(s_cs[1]),
      .din(s_din[1]),
      .fr(fr)
   );

   // ----------------------------------------
   // Write port
   // ----------------------------------------
   logic next_wr_strobe;
   logic [6:0] next_wr_addr;
   logic [7:0] next_wr_data;
   logic next_fast_mode;
   always_comb begin
      next_wr_strobe = 1'b0;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_fast_mode = (sample_period_setting <= srf_pkg::FAST_MAX_SETTING);
      if (fr.frame_done && fr.is_write == srf_pkg::DIR_WRITE) begin
         next_wr_strobe = 1'b1;
         next_wr_addr = fr.addr;
         next_wr_data = fr.data;
      end
      // Read frames change nothing here
   end
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         wr_strobe <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         fast_mode <= 1'b1;
      end else begin
         wr_strobe <= next_wr_strobe;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         fast_mode <= next_fast_mode;
      end
   end

   // ----------------------------------------
   // Data-valid delay
   // ----------------------------------------
   typedef enum logic [1:0] {
      SRF_WAIT = 2'b01,
      SRF_RUN = 2'b10
   } srf_state_e;
   srf_state_e st, next_st;
   logic [24:0] wait_cnt, next_wait_cnt;
   logic next_data_ready;
   logic [24:0] delay_sel;
   always_comb begin
      if (power_on) begin
         delay_sel = next_fast_mode ? 25'(POWER_ON_FAST) : 25'(POWER_ON_NORM);
      end else begin
         delay_sel = next_fast_mode ? 25'(RESET_REC_FAST) : 25'(RESET_REC_NORM);
      end
   end
   logic armed, next_armed;
   always_comb begin
      next_st = st;
      next_wait_cnt = wait_cnt;
      next_armed = 1'b1;
      if (!armed) begin
         next_wait_cnt = delay_sel;
      end
      case (st)
         SRF_WAIT: begin
            if (armed && wait_cnt <= 25'd1) begin
               next_st = SRF_RUN;
            end else if (armed) begin
               next_wait_cnt = wait_cnt - 25'd1;
            end
         end
         SRF_RUN: begin
            if (sleep_rise) begin
               next_st = SRF_WAIT;
               next_wait_cnt = 25'(SLEEP_REC);
            end
         end
         default: next_st = SRF_WAIT;
      endcase
      next_data_ready = (next_st == SRF_RUN);
   end
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         st <= SRF_WAIT;
         wait_cnt <= '0;
         armed <= 1'b0;
         data_ready <= 1'b0;
      end else begin
         st <= next_st;
         wait_cnt <= next_wait_cnt;
         armed <= next_armed;
         data_ready <= next_data_ready;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence srf_sleep_seen;
      sleep_rise && st == SRF_RUN;
   endsequence
   sequence srf_arm_normal;
      !armed && sample_period_setting > srf_pkg::FAST_MAX_SETTING;
   endsequence

   chk_read_no_write: assert property (@(posedge mclk) disable iff (!srst_n)
      fr.frame_done && !fr.is_write |=> !wr_strobe) else $error("read wrote");
   chk_write_stores: assert property (@(posedge mclk) disable iff (!srst_n)
      fr.frame_done && fr.is_write |=> wr_strobe && wr_data == $past(fr.data))
      else $error("write lost");
   chk_mode_select: assert property (@(posedge mclk) disable iff (!srst_n)
      sample_period_setting >= 8'h08 |=> !fast_mode) else $error("mode wrong");
   chk_mode_fast: assert property (@(posedge mclk) disable iff (!srst_n)
      sample_period_setting <= srf_pkg::FAST_MAX_SETTING |=> fast_mode)
      else $error("fast mode wrong");
   chk_sleep_wait: assert property (@(posedge mclk) disable iff (!srst_n)
      sleep_rise && st == SRF_RUN |=> !data_ready [*2]) else $error("ready early");
   chk_sleep_load: assert property (@(posedge mclk) disable iff (!srst_n)
      srf_sleep_seen |=> wait_cnt == 25'(SLEEP_REC)) else $error("sleep wait wrong");
   chk_ready_state: assert property (@(posedge mclk) disable iff (!srst_n)
      data_ready == (st == SRF_RUN)) else $error("ready mismatch");
   chk_addr_take: assert property (@(posedge mclk) disable iff (!srst_n)
      wr_strobe |-> wr_addr == $past(fr.addr)) else $error("bad addr");
   chk_norm_delay: assert property (@(posedge mclk) disable iff (!srst_n)
      srf_arm_normal |=> wait_cnt == ($past(power_on) ? 25'(POWER_ON_NORM)
      : 25'(RESET_REC_NORM))) else $error("normal delay wrong");
   chk_strobe_pulse: assert property (@(posedge mclk) disable iff (!srst_n)
      wr_strobe |=> !wr_strobe) else $error("strobe too long");
   chk_cs_no_done: assert property (@(posedge mclk) disable iff (!srst_n)
      s_cs[1] |=> !fr.frame_done) else $error("done outside frame");
endmodule // srf_port
`default_nettype wire

//--- rtl/srf_pkg.sv
// Purpose: Constants for the serial register frame port
// Assumes: 125 MHz mclk
// Notes: Times kept in their own units, cycle counts derived
package srf_pkg;
   localparam int CLK_MHZ = 125;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int DIR_POS = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   localparam logic DIR_WRITE = 1'b1;
   localparam logic [7:0] FAST_MAX_SETTING = 8'h07;
   localparam logic [7:0] PERIOD_RESET = 8'h01;
   // Start-up, reset and sleep recovery times
   localparam int POWER_ON_FAST_MS = 150;
   localparam int POWER_ON_NORM_MS = 190;
   localparam int RESET_REC_FAST_MS = 30;
   localparam int RESET_REC_NORM_MS = 70;
   localparam int SLEEP_REC_US = 2500;
   localparam int POWER_ON_FAST_CYC = POWER_ON_FAST_MS * 1000 * CLK_MHZ;
   localparam int POWER_ON_NORM_CYC = POWER_ON_NORM_MS * 1000 * CLK_MHZ;
   localparam int RESET_REC_FAST_CYC = RESET_REC_FAST_MS * 1000 * CLK_MHZ;
   localparam int RESET_REC_NORM_CYC = RESET_REC_NORM_MS * 1000 * CLK_MHZ;
   localparam int SLEEP_REC_CYC = SLEEP_REC_US * CLK_MHZ;
   localparam int WAIT_W = 25;
endpackage

//--- rtl/srf_frame_if.sv
// Purpose: Carries a decoded frame between shifter and port
// Assumes: One mclk domain
// Notes: Strobe lasts one cycle
`timescale 1ns/10ps
`default_nettype none
interface srf_frame_if;
   logic frame_done;
   logic is_write;
   logic [6:0] addr;
   logic [7:0] data;
   modport src (output frame_done, output is_write, output addr, output data);
   modport dst (input frame_done, input is_write, input addr, input data);
endinterface
`default_nettype wire

//--- rtl/srf_shifter.sv
// Purpose: Mode 3 sixteen-bit input shifter
// Assumes: Pins already synchronised to mclk
// Notes: Samples data on each rising serial clock while cs_n is low, up to sixteen bits
`timescale 1ns/10ps
`default_nettype none
module srf_shifter (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk_rise,
   input wire logic cs_n,
   input wire logic din,
   srf_frame_if.src fr
);
   logic [15:0] shreg, next_shreg;
   logic [4:0] cnt, next_cnt;
   logic done, next_done;

   always_comb begin
      next_shreg = shreg;
      next_cnt = cnt;
      next_done = 1'b0;
      if (cs_n) begin
         next_cnt = '0;
      end else if (sclk_rise && cnt < 5'(srf_pkg::FRAME_BITS)) begin
         next_shreg = {shreg[14:0], din};
         next_cnt = cnt + 5'd1;
         next_done = (cnt == 5'(srf_pkg::FRAME_BITS - 1));
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= '0;
         cnt <= '0;
         done <= 1'b0;
      end else begin
         shreg <= next_shreg;
         cnt <= next_cnt;
         done <= next_done;
      end
   end

   assign fr.frame_done = done;
   assign fr.is_write = shreg[srf_pkg::DIR_POS];
   assign fr.addr = shreg[srf_pkg::ADDR_MSB:srf_pkg::ADDR_LSB];
   assign fr.data = shreg[7:0];

   chk_count_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      cnt <= 5'(srf_pkg::FRAME_BITS)) else $error("bit count overflow");
   chk_cs_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_n |=> cnt == 5'd0) else $error("count not cleared");
endmodule // srf_shifter
`default_nettype wire

//--- tb/srf_master_model.sv
// Purpose: Behavioural serial master for the frame port
// Assumes: Mode 3, serial clock of 64 ns within frames
// Notes: Sends nbits bits, most significant first
`timescale 1ns/10ps
`default_nettype none
module srf_master_model (
   input wire logic go,
   input wire logic [15:0] word,
   input wire logic [4:0] nbits,
   output logic sclk,
   output logic cs_n,
   output logic din,
   output logic busy
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
      busy = 1'b0;
   end
   always @(posedge go) begin
      busy = 1'b1;
      cs_n = 1'b0;
      #50;
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b0;
         din = word[15 - i];
         #32 sclk = 1'b1;
         #32;
      end
      cs_n = 1'b1;
      din = ~din;
      #41000 busy = 1'b0;
   end
endmodule // srf_master_model
`default_nettype wire

//--- tb/tb_srf_port.sv
// Purpose: Self-checking bench for the frame port
// Assumes: Shortened recovery counts
// Notes: Write frames noted in a queue, monitor compares
`timescale 1ns/10ps
`default_nettype none
module tb_srf_port;
   localparam int PF = 20;
   localparam int RF = 10;
   localparam int SL = 5;
   localparam int PN = 30;
   localparam int RN = 15;
   logic mclk, rst_n, go, power_on, sleep_exit, busy, sclk, cs_n, din;
   logic wr_strobe, fast_mode, data_ready;
   logic [6:0] wr_addr;
   logic [7:0] wr_data, setting, s;
   logic [15:0] word, cmd;
   logic [4:0] nbits;
   logic [14:0] expq[$];
   logic [7:0] modes [4] = '{8'h00, 8'h07, 8'h08, 8'hff};
   int mismatches, checks_done, cyc;

   srf_port #(.POWER_ON_FAST(PF), .POWER_ON_NORM(PN), .RESET_REC_FAST(RF),
      .RESET_REC_NORM(RN), .SLEEP_REC(SL)) u_srf_port (.mclk(mclk), .rst_n(rst_n),
      .sclk(sclk), .cs_n(cs_n), .din(din), .power_on(power_on), .sleep_exit(sleep_exit),
      .sample_period_setting(setting), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
      .wr_data(wr_data), .fast_mode(fast_mode), .data_ready(data_ready));
   srf_master_model u_srf_master_model (.go(go), .word(word), .nbits(nbits),
      .sclk(sclk), .cs_n(cs_n), .din(din), .busy(busy));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task do_reset(input logic po);
      @(posedge mclk);
      rst_n <= 1'b0;
      power_on <= po;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
   endtask

   task ready_in(input int lo, input int hi);
      int n;
      n = 0;
      while (data_ready !== 1'b1 && n < hi) begin
         @(negedge mclk);
         n++;
      end
      check(16'(n >= lo && data_ready === 1'b1), 16'h0001);
   endtask

   task send(input logic [15:0] w, input logic [4:0] n);
      @(posedge mclk);
      word <= w;
      nbits <= n;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      while (busy) @(posedge mclk);
   endtask

   always @(negedge mclk) begin
      cyc++;
      if (cyc > 60000) begin
         mismatches++;
         stop_test;
      end else if (wr_strobe === 1'b1) begin
         if (expq.size() == 0) check(16'h0001, 16'h0000);
         else check({1'b1, wr_addr, wr_data}, {1'b1, expq.pop_front()});
      end
   end

   initial begin
      {rst_n, go, power_on, sleep_exit, word, nbits} = '0;
      cmd = '0;
      setting = 8'h01;
      void'($urandom(32'h5d47));
      do_reset(1'b1);
      ready_in(PF, PF + 8);
      $display("power-on test done");
      for (int i = 0; i < 6; i++) begin
         s = (i < 4) ? modes[i] : 8'($urandom);
         @(posedge mclk);
         setting <= s;
         repeat (3) @(negedge mclk);
         check(16'(fast_mode), 16'(s <= 8'h07));
      end
      @(posedge mclk);
      setting <= 8'h01;
      $display("mode test done");
      for (int i = 0; i < 4; i++) begin
         cmd = {1'b1, 15'($urandom)};
         expq.push_back(cmd[14:0]);
         send(cmd, 5'd16);
      end
      send({1'b0, 15'($urandom)}, 5'd16);
      send({1'b1, 15'($urandom)}, 5'd9);
      cmd = {1'b1, 15'($urandom)};
      expq.push_back(cmd[14:0]);
      send(cmd, 5'd16);
      check(16'(expq.size()), 16'h0000);
      $display("frame test done");
      @(posedge mclk);
      sleep_exit <= 1'b1;
      for (int i = 0; i < 8 && data_ready !== 1'b0; i++) @(negedge mclk);
      check(16'(data_ready), 16'h0000);
      ready_in(SL - 2, SL + 6);
      @(posedge mclk);
      sleep_exit <= 1'b0;
      do_reset(1'b0);
      ready_in(RF, RF + 8);
      @(posedge mclk);
      setting <= 8'h08;
      do_reset(1'b0);
      ready_in(RN, RN + 8);
      do_reset(1'b1);
      ready_in(PN, PN + 8);
      cmd = {1'b1, 15'($urandom)};
      expq.push_back(cmd[14:0]);
      send(cmd, 5'd16);
      check(16'(expq.size()), 16'h0000);
      $display("recovery test done");
      stop_test;
   end
endmodule // tb_srf_port
`default_nettype wire
